// [common/odu_pkg.sv]
// types shared by the octal dac update control block
package odu_pkg;

	typedef logic [15:0] odu_code_t;

	// 24-bit command word, low part of the shift register
	typedef struct packed {
		logic [3:0] cmd;
		logic [3:0] addr;
		odu_code_t  data;
	} odu_word_t;

	// frame as seen at the end of a strobe-low period
	typedef struct packed {
		logic [5:0] nbits;
		odu_word_t  word;
	} odu_frame_t;

	// per-channel output toward the analog side
	typedef struct packed {
		logic       pwr_on;
		logic [2:0] span;
		odu_code_t  code;
	} odu_chan_t;

endpackage

// [common/odu_regs.svh]
// constants for the octal dac update control block
`ifndef ODU_REGS_SVH
`define ODU_REGS_SVH

// frame lengths in serial clock rising edges
`define ODU_FRAME_SHORT   6'h18
`define ODU_FRAME_LONG    6'h20
`define ODU_CNT_MAX       6'h3F

// command codes in word[23:20]
`define ODU_CMD_WR_A      4'h0
`define ODU_CMD_WR_B      4'h1
`define ODU_CMD_WR_A_UPD  4'h2
`define ODU_CMD_UPD_ALL   4'h3
`define ODU_CMD_PWRDN     4'h4
`define ODU_CMD_TOGSEL    4'h5
`define ODU_CMD_MUX       4'h6

// mux control field positions in word data
`define ODU_MUX_EN_BIT    4
`define ODU_MUX_SEL_MSB   3

// codes
`define ODU_ZERO_CODE     16'h0000
`define ODU_MID_CODE      16'h8000

// synchroniser idle levels: cs, upd, tog, clr, temp, reference_comp_pin, straps
`define ODU_SYNC_IDLE     9'h1E8

`endif

// [hw/odu_link.sv]
// serial shift register on the link clock
`include "odu_regs.svh"
module odu_link
	import odu_pkg::*;
(
	// link pins
	input  wire logic select_load_n,
	input  wire logic sck_link,
	input  wire logic sdi,
	output logic      sdo_o,
	output logic      sdo_oe,
	// frame toward the system domain, static while strobe high
	output odu_frame_t frame
);

	logic [31:0] shift_q;
	logic [5:0]  cnt_q;
	logic        first_q;

	// shift only while strobe low
	always_ff @(posedge sck_link) begin
		if (!select_load_n) begin
			shift_q <= {shift_q[30:0], sdi};
		end
	end

	// first edge of a frame restarts the count
	always_ff @(posedge sck_link or posedge select_load_n) begin
		if (select_load_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge sck_link) begin
		if (!select_load_n) begin
			if (first_q) begin
				cnt_q <= 6'h01;
			end else if (cnt_q != `ODU_CNT_MAX) begin
				cnt_q <= cnt_q + 6'h01;
			end
		end
	end

	// echo of the shift register end on the falling edge
	always_ff @(negedge sck_link) begin
		sdo_o <= shift_q[31];
	end

	// released at once when strobe goes high
	always_ff @(negedge sck_link or posedge select_load_n) begin
		if (select_load_n) begin
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= 1'b1;
		end
	end

	assign frame.nbits = cnt_q;
	assign frame.word  = shift_q[23:0];

endmodule // odu_link

// [hw/odu_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
`include "odu_regs.svh"
module odu_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	if (W < 1) begin : g_chk
		$error("odu_sync width must be at least one");
	end

	// no reset: straps must reach the capture flops while reset is low
	always_ff @(posedge clk_sys) begin
		meta_q   <= async_in;
		sync_out <= meta_q;
	end

endmodule // odu_sync

// [hw/odu_top.sv]
// control logic of the octal dac with serial link and update pins
`include "odu_regs.svh"

// Functional notes
// - update pin fall with strobe high updates all
// - update fall during frame waits for strobe
// - update low powers up, blocks power-down
// - strobe low enables shifting on serial clock
// - strobe rise stops shifting, runs command
// - data input sampled on serial clock rise
// - frames of 24 or 32 bits accepted
// - data out is 32-bit register end
// - data out released while strobe high
// - toggle fall loads A, rise loads B
// - toggle affects only selected channels
// - clear low forces strap reset code, span
// - clear resets toggle, mux, update and power controls
// - thermal alarm pulls low above 160 C
// - thermal alarm released on strobe rise
// - three straps pick span and reset code
// - grounded compensation pin starts reference off
// - disabled monitor mux output goes high impedance
module odu_top
	import odu_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	// system clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	// serial link
	input  wire logic                   sck_link,
	input  wire logic                   select_load_n,
	input  wire logic                   sdi,
	output logic                        sdo_o,
	output logic                        sdo_oe,
	// asynchronous control pins
	input  wire logic                   dac_update_n,
	input  wire logic                   toggle_pin,
	input  wire logic                   async_clear_n,
	input  wire logic                   die_over_temp,
	// straps
	input  wire logic                   span_strap_bit0,
	input  wire logic                   span_strap_bit1,
	input  wire logic                   span_strap_bit2,
	input  wire logic                   reference_comp_pin,
	// thermal alarm, open drain
	output logic                        thermal_alarm_n_o,
	output logic                        thermal_alarm_n_oe,
	// analog side controls
	output odu_chan_t [NUM_CH-1:0]      chan_q,
	output logic [2:0]                  power_on_span_select,
	output logic                        ref_enable_q,
	output logic                        analog_monitor_en_q,
	output logic [3:0]                  analog_monitor_sel_q,
	output logic                        analog_monitor_hiz_q
);

	if (NUM_CH < 1 || NUM_CH > 16) begin : g_chk
		$error("odu_top channel count must be 1 to 16");
	end

	odu_frame_t frame;
	logic [8:0] pins_s;
	logic       cs_s;
	logic       upd_s;
	logic       tog_s;
	logic       clr_s;
	logic       temp_s;
	logic       refc_s;
	logic [2:0] strap_s;
	logic       cs_prev_q;
	logic       upd_prev_q;
	logic       tog_prev_q;
	logic       cs_rise;
	logic       upd_fall;
	logic       tog_fall;
	logic       tog_rise;
	logic       frame_ok;
	logic       exec;
	odu_word_t  word_d;
	logic       pend_q;
	logic       upd_all_q;
	logic       init_q;
	logic       clr_act;
	odu_code_t  rst_code;
	logic [NUM_CH-1:0] tsel_q;
	odu_code_t  in_a_q [NUM_CH];
	odu_code_t  in_b_q [NUM_CH];

	// link side, on the serial clock
	odu_link u_link (
		.select_load_n (select_load_n),
		.sck_link      (sck_link),
		.sdi           (sdi),
		.sdo_o         (sdo_o),
		.sdo_oe        (sdo_oe),
		.frame         (frame)
	);

	// all asynchronous levels through two flops
	odu_sync #(
		.W       (9),
		.RST_VAL (`ODU_SYNC_IDLE)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in ({select_load_n, dac_update_n, toggle_pin,
			async_clear_n, die_over_temp, reference_comp_pin,
			span_strap_bit2, span_strap_bit1, span_strap_bit0}),
		.sync_out (pins_s)
	);

	assign cs_s    = pins_s[8];
	assign upd_s   = pins_s[7];
	assign tog_s   = pins_s[6];
	assign clr_s   = pins_s[5];
	assign temp_s  = pins_s[4];
	assign refc_s  = pins_s[3];
	assign strap_s = pins_s[2:0];

	// edge history follows the pins in reset, so no false edge at release
	always_ff @(posedge clk_sys) begin
		cs_prev_q  <= cs_s;
		upd_prev_q <= upd_s;
		tog_prev_q <= tog_s;
	end

	assign cs_rise  = cs_s & ~cs_prev_q;
	assign upd_fall = ~upd_s & upd_prev_q;
	assign tog_fall = ~tog_s & tog_prev_q;
	assign tog_rise = tog_s & ~tog_prev_q;

	// frame is static in the link domain once strobe is high
	assign word_d   = frame.word;
	assign frame_ok = (frame.nbits == `ODU_FRAME_SHORT) ||
		(frame.nbits == `ODU_FRAME_LONG);
	assign exec     = cs_rise & frame_ok;

	// straps and reference mode caught during reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			power_on_span_select <= strap_s;
			ref_enable_q         <= refc_s;
		end
	end

	assign rst_code = power_on_span_select[0] ?
		`ODU_MID_CODE : `ODU_ZERO_CODE;

	// first cycle after reset behaves as a clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			init_q <= 1'b1;
		end else begin
			init_q <= 1'b0;
		end
	end

	assign clr_act = ~clr_s | init_q;

	// deferred update while a frame is open
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clr_act) begin
			pend_q <= 1'b0;
		end else if (upd_fall && !cs_s) begin
			pend_q <= 1'b1;
		end else if (cs_rise) begin
			pend_q <= 1'b0;
		end
	end

	// update of all channels, one cycle after its cause
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clr_act) begin
			upd_all_q <= 1'b0;
		end else begin
			upd_all_q <= (upd_fall && cs_s) ||
				(cs_rise && pend_q) ||
				(exec && word_d.cmd == `ODU_CMD_UPD_ALL);
		end
	end

	// toggle select bits
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clr_act) begin
			tsel_q <= '0;
		end else if (exec && word_d.cmd == `ODU_CMD_TOGSEL) begin
			tsel_q <= word_d.data[NUM_CH-1:0];
		end
	end

	// monitor multiplexer control
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clr_act) begin
			analog_monitor_en_q  <= 1'b0;
			analog_monitor_sel_q <= 4'h0;
			analog_monitor_hiz_q <= 1'b1;
		end else if (exec && word_d.cmd == `ODU_CMD_MUX) begin
			analog_monitor_en_q  <= word_d.data[`ODU_MUX_EN_BIT];
			analog_monitor_sel_q <= word_d.data[`ODU_MUX_SEL_MSB:0];
			analog_monitor_hiz_q <= ~word_d.data[`ODU_MUX_EN_BIT];
		end
	end

	// thermal alarm latch, a new event wins over release
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			thermal_alarm_n_oe <= 1'b0;
		end else if (temp_s) begin
			thermal_alarm_n_oe <= 1'b1;
		end else if (cs_rise) begin
			thermal_alarm_n_oe <= 1'b0;
		end
	end

	// open drain only ever pulls low
	always_ff @(posedge clk_sys) begin
		thermal_alarm_n_o <= 1'b0;
	end

	// per-channel input and dac registers
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic hit;
		logic wr_a;

		assign hit  = exec && (word_d.addr == 4'(g));
		assign wr_a = hit && (word_d.cmd == `ODU_CMD_WR_A ||
			word_d.cmd == `ODU_CMD_WR_A_UPD);

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				in_a_q[g] <= `ODU_ZERO_CODE;
			end else if (clr_act) begin
				in_a_q[g] <= rst_code;
			end else if (wr_a) begin
				in_a_q[g] <= word_d.data;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				in_b_q[g] <= `ODU_ZERO_CODE;
			end else if (clr_act) begin
				in_b_q[g] <= rst_code;
			end else if (hit && word_d.cmd == `ODU_CMD_WR_B) begin
				in_b_q[g] <= word_d.data;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				chan_q[g].code <= `ODU_ZERO_CODE;
			end else if (clr_act) begin
				chan_q[g].code <= rst_code;
			end else if (upd_all_q) begin
				chan_q[g].code <= in_a_q[g];
			end else if (tog_fall && tsel_q[g]) begin
				chan_q[g].code <= in_a_q[g];
			end else if (tog_rise && tsel_q[g]) begin
				chan_q[g].code <= in_b_q[g];
			end else if (hit && word_d.cmd == `ODU_CMD_WR_A_UPD) begin
				chan_q[g].code <= word_d.data;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				chan_q[g].span <= 3'h0;
			end else begin
				chan_q[g].span <= power_on_span_select;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_n || clr_act) begin
				chan_q[g].pwr_on <= 1'b1;
			end else if (!upd_s) begin
				chan_q[g].pwr_on <= 1'b1;
			end else if (hit && word_d.cmd == `ODU_CMD_PWRDN) begin
				chan_q[g].pwr_on <= 1'b0;
			end else if (wr_a && word_d.cmd == `ODU_CMD_WR_A_UPD) begin
				chan_q[g].pwr_on <= 1'b1;
			end
		end
	end

endmodule // odu_top

// [verif/odu_host.sv]
// host link controller model that sends frames and captures echo
module odu_host (
	// link toward the device
	output logic      sck_link,
	output logic      select_load_n,
	output logic      sdi,
	// echo from the device
	input  wire logic sdo_o,
	input  wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] echo;
	initial begin
		sck_link = 1'h0;
		select_load_n = 1'h0;
		sdi = 1'h0;
		echo = 32'h0;
		// one empty strobe pulse gives the link flops a defined start
		#1 select_load_n = 1'h1;
	end
	// msb first, 30 ns link period; sck stands low outside frames
	task automatic send(input logic [31:0] w, input int n);
		select_load_n = 1'h0;
		sdi = w[n - 1];
		#15;
		for (int i = n - 1; i >= 0; i--) begin
			sck_link = 1'h1;
			#15 sck_link = 1'h0;
			#1 echo = {echo[30:0], sdo_oe ? sdo_o : 1'h1};
			if (i > 0) sdi = w[i - 1];
			#14;
		end
		select_load_n = 1'h1;
		// released line shows the inverse of the last bit
		sdi = ~sdi;
		#250;
	endtask
endmodule // odu_host

// [verif/odu_monitor.sv]
// assertion checker for the octal dac update control block
module odu_monitor
	import odu_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	// clock and reset
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	// pins
	input wire logic                 select_load_n,
	input wire logic                 sdo_oe,
	input wire logic                 dac_update_n,
	input wire logic                 async_clear_n,
	input wire logic                 die_over_temp,
	input wire logic                 thermal_alarm_n_o,
	input wire logic                 thermal_alarm_n_oe,
	// outputs
	input wire odu_chan_t [NUM_CH-1:0] chan_q,
	input wire logic [2:0]           power_on_span_select,
	input wire logic                 ref_enable_q,
	input wire logic                 analog_monitor_en_q,
	input wire logic                 analog_monitor_hiz_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [15:0] rc;
	assign rc = power_on_span_select[0] ? 16'h8000 : 16'h0000;
	sdo_release_a: assert property (select_load_n |-> !sdo_oe)
		else $error("sdo driven while strobe high");
	alarm_set_a: assert property (die_over_temp [*3] |-> ##[0:3] thermal_alarm_n_oe)
		else $error("alarm not raised");
	alarm_low_a: assert property (thermal_alarm_n_oe |-> !thermal_alarm_n_o)
		else $error("alarm drives high");
	alarm_release_a: assert property ($fell(thermal_alarm_n_oe) |-> select_load_n)
		else $error("alarm released inside frame");
	mux_hiz_a: assert property (analog_monitor_hiz_q == !analog_monitor_en_q)
		else $error("mux hiz mismatch");
	clear_codes_a: assert property (!async_clear_n [*5] |-> chan_q[0].code == rc && chan_q[NUM_CH-1].code == rc)
		else $error("clear code wrong");
	clear_ctrl_a: assert property (!async_clear_n [*5] |-> !analog_monitor_en_q)
		else $error("clear left mux on");
	update_power_a: assert property (!dac_update_n [*5] |-> chan_q[0].pwr_on && chan_q[NUM_CH-1].pwr_on)
		else $error("channel down while update low");
	strap_hold_a: assert property ($past(rst_n) |-> $stable(power_on_span_select))
		else $error("span straps changed");
	ref_hold_a: assert property ($past(rst_n) |-> $stable(ref_enable_q))
		else $error("reference enable changed");
endmodule // odu_monitor

bind odu_top odu_monitor #(.NUM_CH(NUM_CH)) u_odu_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
	.select_load_n(select_load_n), .sdo_oe(sdo_oe), .dac_update_n(dac_update_n),
	.async_clear_n(async_clear_n), .die_over_temp(die_over_temp), .thermal_alarm_n_o(thermal_alarm_n_o),
	.thermal_alarm_n_oe(thermal_alarm_n_oe), .chan_q(chan_q), .power_on_span_select(power_on_span_select),
	.ref_enable_q(ref_enable_q), .analog_monitor_en_q(analog_monitor_en_q),
	.analog_monitor_hiz_q(analog_monitor_hiz_q));

// [verif/odu_top_tb.sv]
// self-checking bench for the octal dac update control block
module odu_top_tb
	import odu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'h0, rst_n = 1'h0, dac_update_n = 1'h1, toggle_pin = 1'h0;
	logic async_clear_n = 1'h1, die_over_temp = 1'h0, refc = 1'h1;
	logic [2:0]  straps = 3'h0;
	logic [7:0]  tsel = 8'h00;
	logic [15:0] rc;
	logic [31:0] w1;
	wire         sck_link, select_load_n, sdi, sdo_o, sdo_oe, alarm_o, alarm_oe, mux_en, mux_hiz, ref_en;
	wire [3:0]   mux_sel;
	wire [2:0]   span;
	odu_chan_t [7:0] chan_q;
	int num_errors = 0, compares = 0, cycles = 0, seed = 32'hEFA0;
	int a_m[8], b_m[8], d_m[8];
	odu_top u_odu_top (.clk_sys(clk_sys), .rst_n(rst_n), .sck_link(sck_link), .select_load_n(select_load_n),
		.sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .dac_update_n(dac_update_n), .toggle_pin(toggle_pin),
		.async_clear_n(async_clear_n), .die_over_temp(die_over_temp), .span_strap_bit0(straps[0]),
		.span_strap_bit1(straps[1]), .span_strap_bit2(straps[2]), .reference_comp_pin(refc),
		.thermal_alarm_n_o(alarm_o), .thermal_alarm_n_oe(alarm_oe), .chan_q(chan_q),
		.power_on_span_select(span), .ref_enable_q(ref_en), .analog_monitor_en_q(mux_en),
		.analog_monitor_sel_q(mux_sel), .analog_monitor_hiz_q(mux_hiz));
	odu_host u_odu_host (.sck_link(sck_link), .select_load_n(select_load_n), .sdi(sdi), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe));
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_all();
		for (int i = 0; i < 8; i++)
			chk(chan_q[i].code, d_m[i][15:0]);
	endtask
	task automatic clear_model();
		foreach (d_m[i]) begin
			a_m[i] = rc;
			b_m[i] = rc;
			d_m[i] = rc;
		end
		tsel = 8'h00;
	endtask
	// one frame, then the model follows valid frames only
	task automatic frame(input logic [3:0] c, input logic [3:0] n, input logic [15:0] v, input int len);
		u_odu_host.send({8'hA5, c, n, v}, len);
		tick(8);
		if (len == 24 || len == 32) begin
			if (c == 4'h0 || c == 4'h2) a_m[n] = v;
			if (c == 4'h1) b_m[n] = v;
			if (c == 4'h2) d_m[n] = v;
			if (c == 4'h5) tsel = v[7:0];
		end
	endtask
	initial begin
		straps = 3'($random(seed));
		refc = 1'($random(seed));
		rc = straps[0] ? 16'h8000 : 16'h0000;
		tick(3);
		rst_n <= 1'h1;
		tick(4);
		clear_model();
		chk_all();
		chk(span, straps);
		chk(ref_en, refc);
		$display("test reset done");
		for (int i = 0; i < 8; i++) frame(4'h0, i[3:0], 16'($random(seed)), i[0] ? 32 : 24);
		chk_all();
		@(posedge clk_sys) dac_update_n <= 1'h0;
		tick(8);
		d_m = a_m;
		chk_all();
		@(posedge clk_sys) dac_update_n <= 1'h1;
		tick(4);
		for (int i = 0; i < 8; i++) frame(4'h1, i[3:0], 16'($random(seed)), 24);
		frame(4'h5, 4'h0, 16'($random(seed)) | 16'h0001, 24);
		@(posedge clk_sys) toggle_pin <= 1'h1;
		tick(8);
		for (int i = 0; i < 8; i++) if (tsel[i]) d_m[i] = b_m[i];
		chk_all();
		@(posedge clk_sys) toggle_pin <= 1'h0;
		tick(8);
		for (int i = 0; i < 8; i++) if (tsel[i]) d_m[i] = a_m[i];
		chk_all();
		frame(4'h2, 4'h3, 16'h1234, 25);
		chk_all();
		frame(4'h2, 4'h3, 16'h1234, 32);
		chk_all();
		$display("test update and toggle done");
		frame(4'h0, 4'h5, 16'($random(seed)), 24);
		fork
			frame(4'h0, 4'h6, 16'hBEEF, 24);
			begin
				tick(5);
				dac_update_n <= 1'h0;
				tick(8);
				chk_all();
			end
		join
		d_m = a_m;
		chk_all();
		frame(4'h4, 4'h3, 16'h0000, 24);
		chk(chan_q[3].pwr_on, 1'h1);
		@(posedge clk_sys) dac_update_n <= 1'h1;
		tick(4);
		frame(4'h4, 4'h3, 16'h0000, 24);
		chk(chan_q[3].pwr_on, 1'h0);
		w1 = $random(seed) | 32'h00F00000;
		u_odu_host.send(w1, 32);
		u_odu_host.send($random(seed) | 32'h00F00000, 32);
		chk(u_odu_host.echo[31:1], w1[30:0]);
		$display("test pending and echo done");
		@(posedge clk_sys) die_over_temp <= 1'h1;
		tick(6);
		chk({alarm_oe, alarm_o}, 2'h2);
		@(posedge clk_sys) die_over_temp <= 1'h0;
		tick(6);
		chk(alarm_oe, 1'h1);
		frame(4'hF, 4'h0, 16'h0000, 24);
		chk(alarm_oe, 1'h0);
		frame(4'h6, 4'h0, 16'h001A, 24);
		chk({mux_en, mux_hiz, mux_sel}, 6'h2A);
		@(posedge clk_sys) async_clear_n <= 1'h0;
		tick(6);
		clear_model();
		chk_all();
		chk({mux_en, mux_hiz}, 2'h1);
		@(posedge clk_sys) async_clear_n <= 1'h1;
		tick(4);
		frame(4'h1, 4'h0, ~rc, 24);
		@(posedge clk_sys) toggle_pin <= 1'h1;
		tick(8);
		chk_all();
		$display("test alarm and clear done");
		conclude();
	end
endmodule // odu_top_tb
